// ===== rtl/plc_if.sv
// Control and status link between negotiation logic and the PHY
`timescale 1ns/1ns
interface plc_if;
   logic [1:0] link_ctrl;   // Raw code, see plc_lctl_t
   logic       cfg_role;    // Negotiated role, 1 is master
   logic [1:0] link_status; // Raw code, see plc_lstat_t
   modport neg (output link_ctrl, output cfg_role, input link_status);
   modport phy (input link_ctrl, input cfg_role, output link_status);
endinterface

// ===== rtl/plc_neg.sv
// Negotiation end: link control sequencing under AXI4-Lite registers
`timescale 1ns/1ns
module plc_neg
   import plc_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_b,
   plc_if.neg                     lnk,
   input  wire logic              flp_detect,
   input  wire logic [AXI_AW-1:0] s_awaddr,
   input  wire logic              s_awvalid,
   output logic                   s_awready,
   input  wire logic [31:0]       s_wdata,
   input  wire logic [3:0]        s_wstrb,
   input  wire logic              s_wvalid,
   output logic                   s_wready,
   output logic [1:0]             s_bresp,
   output logic                   s_bvalid,
   input  wire logic              s_bready,
   input  wire logic [AXI_AW-1:0] s_araddr,
   input  wire logic              s_arvalid,
   output logic                   s_arready,
   output logic [31:0]            s_rdata,
   output logic [1:0]             s_rresp,
   output logic                   s_rvalid,
   input  wire logic              s_rready,
   output logic                   irq
);

   logic                flp_meta;
   logic                flp_sync;
   logic                flp_seen;
   logic                next_flp_seen;
   plc_lctl_t           state;
   plc_lctl_t           next_state;
   logic                role;
   logic                next_role;
   logic [1:0]          ls_q;
   logic [CTRL_W-1:0]   ctrl;
   logic [CTRL_W-1:0]   next_ctrl;
   logic [IRQ_W-1:0]    ists;
   logic [IRQ_W-1:0]    next_ists;
   logic [IRQ_W-1:0]    imask;
   logic [IRQ_W-1:0]    next_imask;
   logic [IRQ_W-1:0]    evt;
   logic [IRQ_W-1:0]    w1c;
   logic                aw_h;
   logic                w_h;
   logic [AXI_AW-1:0]   aw_a;
   logic [31:0]         w_d;
   logic                w_b0;
   logic                next_aw_h;
   logic                next_w_h;
   logic [AXI_AW-1:0]   next_aw_a;
   logic [31:0]         next_w_d;
   logic                next_w_b0;
   logic                next_bvalid;
   logic [1:0]          next_bresp;
   logic                next_rvalid;
   logic [31:0]         next_rdata;
   logic [1:0]          next_rresp;
   logic                wr_do;
   logic                next_irq;

   // Fast link pulse detect is a pin, two flops before use
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         flp_meta <= 1'b0;
         flp_sync <= 1'b0;
      end else begin
         flp_meta <= flp_detect;
         flp_sync <= flp_meta;
      end
   end

   // Link control sequence
   always_comb begin
      next_state    = state;
      next_flp_seen = flp_seen | flp_sync;
      next_role     = role;
      if (!ctrl[CTRL_AN]) begin
         next_state    = LC_SCAN;
         next_flp_seen = 1'b0;
      end else begin
         unique case (state)
            LC_SCAN: begin
               if (flp_sync) begin
                  next_state = LC_DISABLE;
               end
            end
            LC_DISABLE: begin
               next_role = ctrl[CTRL_MSTR];
               if (ctrl[CTRL_GO]) begin
                  next_state = LC_ENABLE;
               end
            end
            LC_ENABLE: begin
               if (!ctrl[CTRL_GO]) begin
                  next_state = LC_DISABLE;
               end
            end
            default: next_state = LC_SCAN;
         endcase
      end
   end

   // Events: pulses first seen, link up, link lost
   assign evt[IRQ_FLP]  = flp_sync & ~flp_seen & ctrl[CTRL_AN];
   assign evt[IRQ_UP]   = lnk.link_status == LS_OK && ls_q != LS_OK;
   assign evt[IRQ_DOWN] = lnk.link_status == LS_FAIL && ls_q == LS_OK;

   // Write channel: address and data taken in either order
   assign s_awready = !aw_h && !s_bvalid;
   assign s_wready  = !w_h && !s_bvalid;
   assign s_arready = !s_rvalid;
   assign wr_do     = aw_h && w_h;
   assign w1c       = (wr_do && w_b0 && aw_a == REG_IRQ) ?
                      w_d[IRQ_W-1:0] : '0;

   // Bus write side and registers
   always_comb begin
      next_aw_h   = aw_h;
      next_w_h    = w_h;
      next_aw_a   = aw_a;
      next_w_d    = w_d;
      next_w_b0   = w_b0;
      next_bvalid = s_bvalid;
      next_bresp  = s_bresp;
      next_ctrl   = ctrl;
      next_imask  = imask;
      if (s_awvalid && s_awready) begin
         next_aw_h = 1'b1;
         next_aw_a = s_awaddr;
      end
      if (s_wvalid && s_wready) begin
         next_w_h  = 1'b1;
         next_w_d  = s_wdata;
         next_w_b0 = s_wstrb[0];
      end
      if (s_bvalid && s_bready) begin
         next_bvalid = 1'b0;
      end
      if (wr_do) begin
         next_aw_h   = 1'b0;
         next_w_h    = 1'b0;
         next_bvalid = 1'b1;
         next_bresp  = RESP_OKAY;
         unique case (aw_a)
            REG_CTRL: begin
               if (w_b0) begin
                  next_ctrl = w_d[CTRL_W-1:0];
               end
            end
            REG_MASK: begin
               if (w_b0) begin
                  next_imask = w_d[IRQ_W-1:0];
               end
            end
            REG_IRQ, REG_STAT: begin
            end
            default: next_bresp = RESP_SLVERR;
         endcase
      end
      // Set wins over a write-one clear in the same cycle
      next_ists = (ists & ~w1c) | evt;
      next_irq  = |(next_ists & next_imask);
   end

   // Bus read side
   always_comb begin
      next_rvalid = s_rvalid;
      next_rdata  = s_rdata;
      next_rresp  = s_rresp;
      if (s_rvalid && s_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_arvalid && s_arready) begin
         next_rvalid = 1'b1;
         next_rresp  = RESP_OKAY;
         next_rdata  = '0;
         unique case (s_araddr)
            REG_CTRL: next_rdata[CTRL_W-1:0] = ctrl;
            REG_STAT: begin
               next_rdata[STAT_LS +: 2] = lnk.link_status;
               next_rdata[STAT_LC +: 2] = state;
               next_rdata[STAT_FLP]     = flp_seen;
            end
            REG_IRQ:  next_rdata[IRQ_W-1:0] = ists;
            REG_MASK: next_rdata[IRQ_W-1:0] = imask;
            default:  next_rresp = RESP_SLVERR;
         endcase
      end
   end

   // All state registered on every edge
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state    <= LC_SCAN;
         flp_seen <= 1'b0;
         role     <= CFG_SLAVE;
         ls_q     <= LS_FAIL;
         ctrl     <= '0;
         ists     <= '0;
         imask    <= '0;
         aw_h     <= 1'b0;
         w_h      <= 1'b0;
         aw_a     <= '0;
         w_d      <= '0;
         w_b0     <= 1'b0;
         s_bvalid <= 1'b0;
         s_bresp  <= RESP_OKAY;
         s_rvalid <= 1'b0;
         s_rdata  <= '0;
         s_rresp  <= RESP_OKAY;
         irq      <= 1'b0;
      end else begin
         state    <= next_state;
         flp_seen <= next_flp_seen;
         role     <= next_role;
         ls_q     <= lnk.link_status;
         ctrl     <= next_ctrl;
         ists     <= next_ists;
         imask    <= next_imask;
         aw_h     <= next_aw_h;
         w_h      <= next_w_h;
         aw_a     <= next_aw_a;
         w_d      <= next_w_d;
         w_b0     <= next_w_b0;
         s_bvalid <= next_bvalid;
         s_bresp  <= next_bresp;
         s_rvalid <= next_rvalid;
         s_rdata  <= next_rdata;
         s_rresp  <= next_rresp;
         irq      <= next_irq;
      end
   end

   assign lnk.link_ctrl = state;
   assign lnk.cfg_role  = role;

endmodule

// ===== rtl/plc_phy.sv
// PHY end: link monitor status, PHY control mode, role and symbol output
`timescale 1ns/1ns
module plc_phy
   import plc_pkg::*;
#(
   parameter int PAIRS = 4
)(
   input  wire logic                   clk,
   input  wire logic                   rst_b,
   plc_if.phy                          lnk,
   input  wire logic                   sig_detect,
   input  wire logic                   loc_rcvr_ok,
   input  wire logic                   rem_rcvr_ok,
   input  wire logic                   tx_en,
   input  wire logic [2*PAIRS-1:0]     tx_data,
   output logic      [1:0]             pcs_link_status,
   output logic      [1:0]             pcs_tx_mode,
   output logic                        cfg_role,
   output logic      [PAIRS*SYM_W-1:0] tx_symb
);

   // One data octet spreads two bits per pair
   if (PAIRS != 4) begin : g_bad_pairs
      $error("plc_phy serves exactly four pairs");
   end

   // Idle level from two pseudo random bits, never plus or minus one
   function automatic logic [2:0] idle_sym(input logic [1:0] r);
      logic [2:0] s;
      unique case (r)
         2'h1:    s = SYM_P2;
         2'h2:    s = SYM_M2;
         default: s = SYM_Z;
      endcase
      return s;
   endfunction

   // Data level from two frame bits, four levels, never zero
   function automatic logic [2:0] data_sym(input logic [1:0] d);
      logic [2:0] s;
      unique case (d)
         2'h0:    s = SYM_M2;
         2'h1:    s = SYM_M1;
         2'h2:    s = SYM_P1;
         default: s = SYM_P2;
      endcase
      return s;
   endfunction

   plc_lctl_t                lctl;
   logic                     sd_meta;
   logic                     sd_sync;
   plc_lstat_t               lstat;
   plc_lstat_t               next_lstat;
   plc_txmode_t              tmode;
   plc_txmode_t              next_tmode;
   logic                     role;
   logic                     next_role;
   logic      [LFSR_W-1:0]   lfsr;
   logic      [LFSR_W-1:0]   next_lfsr;
   logic [PAIRS*SYM_W-1:0]   next_symb;

   // Unused control code is read as scanning, the safest value
   always_comb begin
      unique case (lnk.link_ctrl)
         LC_DISABLE: lctl = LC_DISABLE;
         LC_ENABLE:  lctl = LC_ENABLE;
         default: lctl = LC_SCAN;
      endcase
   end

   // Pin synchroniser for the medium signal detect
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sd_meta <= 1'b0;
         sd_sync <= 1'b0;
      end else begin
         sd_meta <= sig_detect;
         sd_sync <= sd_meta;
      end
   end

   // Link monitor status
   always_comb begin
      next_lstat = LS_FAIL;
      if (lctl == LC_ENABLE && sd_sync) begin
         if (loc_rcvr_ok) begin
            next_lstat = LS_OK;
         end else begin
            next_lstat = LS_READY;
         end
      end else begin
         next_lstat = LS_FAIL;
      end
   end

   // PHY control transmit mode
   always_comb begin
      next_tmode = TM_ZERO;
      if (lctl != LC_ENABLE || lstat == LS_FAIL) begin
         next_tmode = TM_ZERO;
      end else if (lstat == LS_OK && rem_rcvr_ok) begin
         next_tmode = TM_NORMAL;
      end else begin
         next_tmode = TM_IDLE;
      end
   end

   // Role is taken while negotiation decides and frozen once enabled
   always_comb begin
      next_role = role;
      if (lctl == LC_DISABLE) begin
         next_role = lnk.cfg_role;
      end
   end

   // Idle pattern generator runs on every symbol cycle
   always_comb begin
      next_lfsr = {lfsr[LFSR_W-2:0], lfsr[LFSR_TAPA] ^ lfsr[LFSR_TAPB]};
   end

   // Per-pair symbol selection by transmit mode
   for (genvar p = 0; p < PAIRS; p++) begin : g_pair
      always_comb begin
         unique case (tmode)
            TM_NORMAL: begin
               if (tx_en) begin
                  next_symb[p*SYM_W +: SYM_W] =
                     data_sym(tx_data[2*p +: 2]);
               end else begin
                  next_symb[p*SYM_W +: SYM_W] =
                     idle_sym(lfsr[2*p +: 2]);
               end
            end
            TM_IDLE: begin
               next_symb[p*SYM_W +: SYM_W] =
                  idle_sym(lfsr[2*p +: 2]);
            end
            default: begin
               next_symb[p*SYM_W +: SYM_W] = SYM_Z;
            end
         endcase
      end
   end

   // Status, mode, role and symbols registered every cycle
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         lstat   <= LS_FAIL;
         tmode   <= TM_ZERO;
         role    <= CFG_SLAVE;
         lfsr    <= LFSR_SEED;
         tx_symb <= '0;
      end else begin
         lstat   <= next_lstat;
         tmode   <= next_tmode;
         role    <= next_role;
         lfsr    <= next_lfsr;
         tx_symb <= next_symb;
      end
   end

   // One status value shared by all consumers
   assign lnk.link_status     = lstat;
   assign pcs_link_status     = lstat;
   assign pcs_tx_mode         = tmode;
   assign cfg_role            = role;

endmodule

// ===== rtl/plc_pkg.sv
// Shared encodings and constants for the link and transmit mode control
package plc_pkg;
   // Link control from negotiation, code 2'h3 is unused
   typedef enum logic [1:0] {
      LC_SCAN    = 2'h0,
      LC_DISABLE = 2'h1,
      LC_ENABLE  = 2'h2
   } plc_lctl_t;
   // Link status from the link monitor, code 2'h3 is unused
   typedef enum logic [1:0] {
      LS_FAIL  = 2'h0,
      LS_READY = 2'h1,
      LS_OK    = 2'h2
   } plc_lstat_t;
   // Transmit mode from PHY control, code 2'h3 is unused
   typedef enum logic [1:0] {
      TM_ZERO   = 2'h0,
      TM_IDLE   = 2'h1,
      TM_NORMAL = 2'h2
   } plc_txmode_t;
   localparam logic       CFG_SLAVE  = 1'b0;
   localparam logic       CFG_MASTER = 1'b1;
   // Quinary symbol levels, 3-bit two's complement
   localparam int         SYM_W  = 3;
   localparam logic [2:0] SYM_P2 = 3'h2;
   localparam logic [2:0] SYM_P1 = 3'h1;
   localparam logic [2:0] SYM_Z  = 3'h0;
   localparam logic [2:0] SYM_M1 = 3'h7;
   localparam logic [2:0] SYM_M2 = 3'h6;
   // Idle pattern generator
   localparam int          LFSR_W    = 15;
   localparam logic [14:0] LFSR_SEED = 15'h7FFF;
   localparam int          LFSR_TAPA = 14;
   localparam int          LFSR_TAPB = 13;
   // Register map of the negotiation controller
   localparam int         AXI_AW    = 4;
   localparam logic [3:0] REG_CTRL  = 4'h0;
   localparam logic [3:0] REG_STAT  = 4'h4;
   localparam logic [3:0] REG_IRQ   = 4'h8;
   localparam logic [3:0] REG_MASK  = 4'hC;
   localparam int         CTRL_W    = 3;
   localparam int         CTRL_AN   = 0;
   localparam int         CTRL_GO   = 1;
   localparam int         CTRL_MSTR = 2;
   localparam int         IRQ_W     = 3;
   localparam int         IRQ_FLP   = 0;
   localparam int         IRQ_UP    = 1;
   localparam int         IRQ_DOWN  = 2;
   localparam int         STAT_LS   = 0;
   localparam int         STAT_LC   = 2;
   localparam int         STAT_FLP  = 4;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== tb/phy_link_and_tx_mode_control_tb.sv
// Testbench joining both ends, registers reached over AXI4-Lite
`timescale 1ns/1ns
module phy_link_and_tx_mode_control_tb;
   import plc_pkg::*;
   logic        clk, rst_b, sig_detect, loc_rcvr_ok, rem_rcvr_ok, tx_en;
   logic        flp_detect, cfg_role, irq;
   logic [7:0]  tx_data;
   logic [1:0]  pcs_link_status, pcs_tx_mode, s_bresp, s_rresp;
   logic [11:0] tx_symb;
   logic [3:0]  s_awaddr, s_araddr, s_wstrb;
   logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid;
   logic        s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
   logic [31:0] s_wdata, s_rdata;
   int          n_errors, checks;

   plc_if u_plc_if ();
   plc_phy #(.PAIRS(4)) u_plc_phy (.clk(clk), .rst_b(rst_b),
      .lnk(u_plc_if), .sig_detect(sig_detect), .loc_rcvr_ok(loc_rcvr_ok),
      .rem_rcvr_ok(rem_rcvr_ok), .tx_en(tx_en), .tx_data(tx_data),
      .pcs_link_status(pcs_link_status), .pcs_tx_mode(pcs_tx_mode),
      .cfg_role(cfg_role), .tx_symb(tx_symb));
   plc_neg u_plc_neg (.clk(clk), .rst_b(rst_b), .lnk(u_plc_if),
      .flp_detect(flp_detect), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
      .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
      .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
      .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
      .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
      .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
      .irq(irq));
   plc_chk u_plc_chk (.clk(clk), .rst_b(rst_b),
      .link_ctrl(u_plc_if.link_ctrl), .cfg_role(u_plc_if.cfg_role),
      .link_status(u_plc_if.link_status));

   // Clock, 8 ns period
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Compare and count
   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Write one register, check the response code
   task automatic wr(input string nm, input logic [3:0] a,
                     input logic [31:0] d, input logic [1:0] er);
      logic aw_p, w_p;
      aw_p = 1'b1;
      w_p = 1'b1;
      @(posedge clk);
      s_awaddr  <= a;
      s_awvalid <= 1'b1;
      s_wdata   <= d;
      s_wstrb   <= 4'hF;
      s_wvalid  <= 1'b1;
      s_bready  <= 1'b1;
      while (aw_p || w_p) begin
         @(posedge clk);
         if (aw_p && s_awready) begin
            s_awvalid <= 1'b0;
            aw_p = 1'b0;
         end
         if (w_p && s_wready) begin
            s_wvalid <= 1'b0;
            w_p = 1'b0;
         end
      end
      while (!s_bvalid) @(posedge clk);
      check(nm, s_bresp, er);
      s_bready <= 1'b0;
   endtask

   // Read one register, check data and response code
   task automatic rd(input string nm, input logic [3:0] a,
                     input logic [31:0] exp, input logic [1:0] er);
      @(posedge clk);
      s_araddr  <= a;
      s_arvalid <= 1'b1;
      s_rready  <= 1'b1;
      @(posedge clk);
      while (!s_arready) @(posedge clk);
      s_arvalid <= 1'b0;
      @(posedge clk);
      while (!s_rvalid) @(posedge clk);
      check(nm, s_rdata, exp);
      check(nm, s_rresp, er);
      s_rready <= 1'b0;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Every pair symbol within plus two, zero, minus two
   task automatic idle_syms(input string nm);
      logic ok;
      repeat (16) begin
         @(posedge clk);
         ok = 1'b1;
         for (int p = 0; p < 4; p++) begin
            if (!(tx_symb[3*p+:3] inside {SYM_P2, SYM_Z, SYM_M2})) begin
               ok = 1'b0;
            end
         end
         check(nm, ok, 1'b1);
      end
   endtask

   task automatic results();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      n_errors = 0;
      checks = 0;
      rst_b = 1'b0;
      {sig_detect, loc_rcvr_ok, rem_rcvr_ok, tx_en, flp_detect} = 5'h00;
      tx_data = 8'h00;
      {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
      {s_awaddr, s_araddr, s_wstrb} = 12'h000;
      s_wdata = 32'h0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      settle(2);
      check("status", pcs_link_status, LS_FAIL);
      check("symbols", tx_symb, 12'h000);
      check("irq", irq, 1'b0);
      rd("stat", REG_STAT, 32'h0, RESP_OKAY);
      rd("unmapped", 4'h2, 32'h0, RESP_SLVERR);
      wr("unmapped", 4'h2, 32'hFF, RESP_SLVERR);
      rd("ctrl", REG_CTRL, 32'h0, RESP_OKAY);
      // Medium present, negotiation off
      sig_detect <= 1'b1;
      loc_rcvr_ok <= 1'b1;
      rem_rcvr_ok <= 1'b1;
      settle(8);
      check("scan status", pcs_link_status, LS_FAIL);
      check("scan mode", pcs_tx_mode, TM_ZERO);
      // Pulses seen: disable, role captured
      wr("ctrl", REG_CTRL, 32'h5, RESP_OKAY);
      flp_detect <= 1'b1;
      settle(8);
      check("lctl", u_plc_if.link_ctrl, LC_DISABLE);
      check("dis status", pcs_link_status, LS_FAIL);
      check("role", cfg_role, CFG_MASTER);
      rd("stat dis", REG_STAT, 32'h14, RESP_OKAY);
      flp_detect <= 1'b0;
      check("irq masked", irq, 1'b0);
      wr("mask", REG_MASK, 32'h1, RESP_OKAY);
      settle(3);
      check("irq on", irq, 1'b1);
      rd("irq", REG_IRQ, 32'h1, RESP_OKAY);
      wr("clear", REG_IRQ, 32'h1, RESP_OKAY);
      settle(3);
      check("irq off", irq, 1'b0);
      rd("irq clr", REG_IRQ, 32'h0, RESP_OKAY);
      // Enabled with unreliable local receiver
      loc_rcvr_ok <= 1'b0;
      tx_en <= 1'b1;
      tx_data <= 8'hE4;
      wr("go", REG_CTRL, 32'h7, RESP_OKAY);
      settle(8);
      check("ready", pcs_link_status, LS_READY);
      check("idle mode", pcs_tx_mode, TM_IDLE);
      idle_syms("idle syms");
      wr("role", REG_CTRL, 32'h3, RESP_OKAY);
      settle(4);
      check("role held", cfg_role, CFG_MASTER);
      // Local reliable, remote not: training
      loc_rcvr_ok <= 1'b1;
      rem_rcvr_ok <= 1'b0;
      settle(8);
      check("ok", pcs_link_status, LS_OK);
      check("shared", pcs_link_status, u_plc_if.link_status);
      check("train mode", pcs_tx_mode, TM_IDLE);
      idle_syms("train syms");
      rd("stat ok", REG_STAT, 32'h1A, RESP_OKAY);
      // Both reliable: normal, frame data mapped
      rem_rcvr_ok <= 1'b1;
      settle(6);
      check("normal", pcs_tx_mode, TM_NORMAL);
      check("data syms", tx_symb, 12'h47E);
      tx_en <= 1'b0;
      settle(3);
      check("normal held", pcs_tx_mode, TM_NORMAL);
      idle_syms("gap syms");
      // Medium lost
      sig_detect <= 1'b0;
      settle(8);
      check("lost", pcs_link_status, LS_FAIL);
      check("lost mode", pcs_tx_mode, TM_ZERO);
      check("zero syms", tx_symb, 12'h000);
      check("irq masked2", irq, 1'b0);
      rd("irq ev", REG_IRQ, 32'h6, RESP_OKAY);
      wr("mask all", REG_MASK, 32'h7, RESP_OKAY);
      settle(3);
      check("irq ev on", irq, 1'b1);
      // Negotiation off again
      wr("ctrl off", REG_CTRL, 32'h0, RESP_OKAY);
      settle(4);
      check("lctl scan", u_plc_if.link_ctrl, LC_SCAN);
      wr("clear all", REG_IRQ, 32'h7, RESP_OKAY);
      settle(3);
      check("irq end", irq, 1'b0);
      results();
   end

   // Watchdog against a hang
   initial begin
      #(8 * 20000);
      n_errors++;
      results();
   end
endmodule

// ===== tb/plc_chk.sv
// Checker on the link control and status signals between both ends
`timescale 1ns/1ns
module plc_chk
   import plc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic [1:0] link_ctrl,
   input  wire logic       cfg_role,
   input  wire logic [1:0] link_status
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   // Status follows control one edge later
   scan_fail_a: assert property (link_ctrl == LC_SCAN |=>
      link_status == LS_FAIL) else $error("status not fail in scan");
   disable_fail_a: assert property (link_ctrl == LC_DISABLE |=>
      link_status == LS_FAIL) else $error("status not fail in disable");
   live_needs_enable_a: assert property (link_status != LS_FAIL |->
      $past(link_ctrl) == LC_ENABLE) else $error("live status without enable");
   scan_hold_a: assert property ((link_ctrl == LC_SCAN)[*3] |->
      link_status == LS_FAIL && $past(link_status) == LS_FAIL)
      else $error("status moved during long scan");
   // Unused codes never driven
   stat_code_a: assert property (link_status != 2'h3)
      else $error("unused status code");
   ctrl_code_a: assert property (link_ctrl != 2'h3)
      else $error("unused control code");
   // Control sequencing of the negotiation end
   leave_scan_a: assert property (link_ctrl == LC_SCAN ##1
      link_ctrl != LC_SCAN |-> link_ctrl == LC_DISABLE)
      else $error("scan left for other than disable");
   enter_enable_a: assert property ($changed(link_ctrl) &&
      link_ctrl == LC_ENABLE |-> $past(link_ctrl) == LC_DISABLE)
      else $error("enable entered from other than disable");
   // Role only moves while configuration is being decided
   role_frozen_a: assert property (link_ctrl != LC_DISABLE |=>
      $stable(cfg_role)) else $error("role changed outside disable");

   // Main scenarios reached
   cover property (link_ctrl == LC_ENABLE && cfg_role);
   cover property (link_status == LS_OK);
endmodule
